// >>> src/rx_pause_filter_defs.svh
// Constants for the receive pause and control frame qualifier.
`ifndef RX_PAUSE_FILTER_DEFS_SVH
`define RX_PAUSE_FILTER_DEFS_SVH

// Register byte offsets on the APB
`define OFS_CTRL          8'h00
`define OFS_PAUSE_EN      8'h04
`define OFS_UCAST_LO      8'h08
`define OFS_UCAST_HI      8'h0c
`define OFS_MCAST_LO      8'h10
`define OFS_MCAST_HI      8'h14
`define OFS_SRC_LO        8'h18
`define OFS_SRC_HI        8'h1c
`define OFS_ETYPE         8'h20
`define OFS_GCP_OPC       8'h24
`define OFS_PCP_OPC       8'h28
`define OFS_STATUS        8'h2c

// Bit positions in the control register
`define BIT_FWD           0
`define BIT_CHK_ACK       1
`define BIT_GCP_EN        2
`define BIT_GCP_MC        3
`define BIT_GCP_UC        4
`define BIT_GCP_SA        5
`define BIT_GCP_ET        6
`define BIT_GCP_OP        7
`define BIT_PCP_EN        8
`define BIT_PCP_MC        9
`define BIT_PCP_UC        10
`define BIT_PCP_SA        11
`define BIT_PCP_ET        12
`define BIT_PCP_OP        13
`define BIT_GPP_EN        14

// Status register: pending classes low, reported valid high
`define STAT_VALID_LSB    16

// Reset values
`define RST_ETYPE         16'h8808
`define RST_GCP_OPMIN     16'h0001
`define RST_GCP_OPMAX     16'h0001
`define RST_PCP_OPMIN     16'h0101
`define RST_PCP_OPMAX     16'h0101
`define RST_PAUSE_EN      9'h1ff

// Opcodes that make a control frame a pause frame
`define OPC_GLOBAL_PAUSE  16'h0001
`define OPC_PRIO_PAUSE    16'h0101

// Class index of the global pause
`define GLOBAL_CLASS      8

`endif

// >>> src/rx_pause_filter_pkg.sv
// Types shared by the receive pause and control frame qualifier.
package rx_pause_filter_pkg;

    // Static configuration held in the APB registers
    typedef struct packed {
        logic        forward_ctrl;        // Deliver control frames
        logic        check_ack;           // Hold pause until acknowledged
        logic        gcp_enable;          // Global control recognition
        logic        gcp_mcast_check;     // Global: multicast dest compare
        logic        gcp_ucast_check;     // Global: unicast dest compare
        logic        rx_global_ctrl_src_check; // Global: source compare
        logic        gcp_etype_check;     // Global: ethertype compare
        logic        gcp_opcode_check;    // Global: opcode range compare
        logic        pcp_enable;          // Priority control recognition
        logic        pcp_mcast_check;     // Priority: multicast dest
        logic        pcp_ucast_check;     // Priority: unicast dest
        logic        rx_prio_ctrl_src_check;   // Priority: source compare
        logic        pcp_etype_check;     // Priority: ethertype compare
        logic        pcp_opcode_check;    // Priority: opcode range
        logic        gpp_enable;          // Global pause recognition
        logic [8:0]  pause_enable;        // Per-class report enables
        logic [47:0] rx_pause_unicast_dest_addr;   // Unicast pause address
        logic [47:0] rx_pause_multicast_dest_addr; // Multicast address
        logic [47:0] rx_pause_source_addr;         // Source address
        logic [15:0] gcp_etype;           // Global ethertype
        logic [15:0] pcp_etype;           // Priority ethertype
        logic [15:0] gcp_opcode_min;      // Global opcode low bound
        logic [15:0] gcp_opcode_max;      // Global opcode high bound
        logic [15:0] pcp_opcode_min;      // Priority opcode low bound
        logic [15:0] pcp_opcode_max;      // Priority opcode high bound
    } cfg_t;

    // Parsed header of one received frame
    typedef struct packed {
        logic [47:0]      dest_addr;      // Destination address
        logic [47:0]      src_addr;       // Source address
        logic [15:0]      ethertype;      // Ethertype field
        logic [15:0]      opcode;         // Control opcode
        logic [7:0]       class_enable;   // Priority class vector
        logic [7:0][15:0] quanta;         // Quanta; global uses entry 0
    } rx_hdr_t;

    // Verdict on one frame
    typedef struct packed {
        logic deliver;                    // Frame goes to the user
        logic discard;                    // Frame is dropped
        logic is_ctrl;                    // Frame was a control frame
    } verdict_t;

endpackage

// >>> src/rx_pause_filter.sv
// Receive control frame qualifier with pause reporting and APB registers.
//
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "rx_pause_filter_defs.svh"

// What this block does
// - Forward control frames when set, else drop
// - Ack bus used only when wait-ack set
// - Per-class enable gates only reported pause
// - Global control enable turns on recognition
// - Global control multicast destination compare
// - Global control unicast destination compare
// - Unicast pause address is 48-bit setting
// - Global control source address compare
// - Pause source address is 48-bit setting
// - Global control ethertype compare
// - Global control opcode min/max compare
// - Priority control enable turns on recognition
// - Priority control multicast destination compare
// - Priority control unicast destination compare
// - Multicast pause address is 48-bit setting
// - Priority control source address compare
// - Priority control ethertype compare
// - Priority control opcode min/max compare
// - Global pause enable turns on recognition
// - Standard pause sets valid bit 8
// - Quanta reported per class, global at 8
module rx_pause_filter (
    input  wire logic                          pclk,           // APB clock
    input  wire logic                          presetn,        // Reset, low
    input  wire logic                          psel,           // APB select
    input  wire logic                          penable,        // APB enable
    input  wire logic                          pwrite,         // APB write
    input  wire logic [7:0]                    paddr,          // APB address
    input  wire logic [31:0]                   pwdata,         // Write data
    output logic      [31:0]                   prdata,         // Read data
    output logic                               pready,         // Always ready
    output logic                               pslverr,        // Bad address
    input  wire logic                          rx_hdr_valid,   // Header pulse
    input  wire rx_pause_filter_pkg::rx_hdr_t  rx_hdr,         // Header
    input  wire logic [8:0]                    rx_pause_ack,   // User ack
    output rx_pause_filter_pkg::verdict_t      rx_verdict,     // Frame verdict
    output logic                               rx_verdict_valid, // Pulse
    output logic      [8:0]                    rx_pause_valid, // Per class
    output logic      [8:0][15:0]              rx_received_quanta // Quanta
);

    // Configuration registers
    rx_pause_filter_pkg::cfg_t cfg_q;           // Current settings
    rx_pause_filter_pkg::cfg_t cfg_d;           // Next settings

    // APB read path registers
    logic [31:0]               rdata_q;         // Read data held
    logic [31:0]               rdata_d;         // Read data next
    logic                      slverr_q;        // Error flag held
    logic                      slverr_d;        // Error flag next

    // Frame verdict registers
    rx_pause_filter_pkg::verdict_t verdict_q;   // Verdict held
    rx_pause_filter_pkg::verdict_t verdict_d;   // Verdict next
    logic                      vvalid_q;        // Verdict strobe
    logic                      vvalid_d;        // Verdict strobe next

    // Pause state registers
    logic [8:0]                pend_q;          // Classes being processed
    logic [8:0]                pend_d;          // Next pending
    logic [8:0]                pvalid_q;        // Reported valid
    logic [8:0]                pvalid_d;        // Next reported valid
    logic [8:0][15:0]          quanta_q;        // Reported quanta
    logic [8:0][15:0]          quanta_d;        // Next quanta

    // Classification terms
    logic                      is_gcp;          // Qualified global control
    logic                      is_pcp;          // Qualified priority control
    logic                      is_gpp;          // Global pause frame
    logic                      is_ppp;          // Priority pause frame
    logic [8:0]                new_pause;       // Classes set by this frame

    // APB phase decode
    logic                      apb_setup;       // Setup cycle
    logic                      apb_write;       // Write access cycle

    assign apb_setup = psel & ~penable;
    assign apb_write = psel & penable & pwrite;

    // Qualify one control type; every enabled check must pass, except that one matching destination address compare is enough
    function automatic logic ctrl_match(
        input logic                       en,
        input logic                       mc_chk,
        input logic                       uc_chk,
        input logic                       sa_chk,
        input logic                       et_chk,
        input logic                       op_chk,
        input logic [15:0]                etype,
        input logic [15:0]                opmin,
        input logic [15:0]                opmax,
        input rx_pause_filter_pkg::cfg_t  c,
        input rx_pause_filter_pkg::rx_hdr_t h
    );
        logic da_ok;
        logic sa_ok;
        logic et_ok;
        logic op_ok;
        // Either enabled address compare may pass the destination
        da_ok = ~(mc_chk | uc_chk)
              | (mc_chk & (h.dest_addr == c.rx_pause_multicast_dest_addr))
              | (uc_chk & (h.dest_addr == c.rx_pause_unicast_dest_addr));
        sa_ok = ~sa_chk | (h.src_addr == c.rx_pause_source_addr);
        et_ok = ~et_chk | (h.ethertype == etype);
        // Range is inclusive at both ends
        op_ok = ~op_chk | ((h.opcode >= opmin) & (h.opcode <= opmax));
        ctrl_match = en & da_ok & sa_ok & et_ok & op_ok;
    endfunction

    // Frame classification
    always_comb begin
        // Global control: enable, dest, source, ethertype, opcode
        is_gcp = ctrl_match(cfg_q.gcp_enable,
                            cfg_q.gcp_mcast_check,
                            cfg_q.gcp_ucast_check,
                            cfg_q.rx_global_ctrl_src_check,
                            cfg_q.gcp_etype_check,
                            cfg_q.gcp_opcode_check,
                            cfg_q.gcp_etype,
                            cfg_q.gcp_opcode_min,
                            cfg_q.gcp_opcode_max,
                            cfg_q, rx_hdr);
        // Priority control: same checks on its own settings
        is_pcp = ctrl_match(cfg_q.pcp_enable,
                            cfg_q.pcp_mcast_check,
                            cfg_q.pcp_ucast_check,
                            cfg_q.rx_prio_ctrl_src_check,
                            cfg_q.pcp_etype_check,
                            cfg_q.pcp_opcode_check,
                            cfg_q.pcp_etype,
                            cfg_q.pcp_opcode_min,
                            cfg_q.pcp_opcode_max,
                            cfg_q, rx_hdr);
        // Pause frames are qualified control frames with pause opcodes
        is_gpp = cfg_q.gpp_enable & is_gcp
               & (rx_hdr.opcode == `OPC_GLOBAL_PAUSE);
        is_ppp = is_pcp & (rx_hdr.opcode == `OPC_PRIO_PAUSE);
        // Classes touched by this frame, before report gating
        new_pause = 9'h000;
        if (rx_hdr_valid) begin
            new_pause[`GLOBAL_CLASS] = is_gpp;
            new_pause[7:0] = is_ppp ? rx_hdr.class_enable : 8'h00;
        end
    end

    // Frame verdict: control frames forwarded or dropped
    always_comb begin
        verdict_d = '0;
        vvalid_d  = rx_hdr_valid;
        if (rx_hdr_valid) begin
            verdict_d.is_ctrl = is_gcp | is_pcp;
            if (is_gcp | is_pcp) begin
                // Control frame follows the forward setting
                verdict_d.deliver = cfg_q.forward_ctrl;
                verdict_d.discard = ~cfg_q.forward_ctrl;
            end else begin
                // Ordinary frames always pass
                verdict_d.deliver = 1'b1;
            end
        end
    end

    // Verdict registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            verdict_q <= '0;
            vvalid_q  <= 1'b0;
        end else begin
            verdict_q <= verdict_d;
            vvalid_q  <= vvalid_d;
        end
    end

    // Pause processing and user report
    always_comb begin
        pend_d   = pend_q;
        quanta_d = quanta_q;
        if (cfg_q.check_ack) begin
            // Hold each class until its ack; a new pause beats the ack
            pend_d = (pend_q & ~rx_pause_ack) | new_pause;
        end else begin
            // Ack bus ignored; each pause is a one-cycle indication
            pend_d = new_pause;
        end
        // Capture quanta of every class this frame carries
        for (int i = 0; i < 8; i++) begin
            if (new_pause[i]) begin
                quanta_d[i] = rx_hdr.quanta[i];
            end
        end
        if (new_pause[`GLOBAL_CLASS]) begin
            quanta_d[`GLOBAL_CLASS] = rx_hdr.quanta[0];
        end
        // Report only enabled classes; internal state is not gated
        pvalid_d = pend_d & cfg_q.pause_enable;
    end

    // Pause registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_q   <= 9'h000;
            pvalid_q <= 9'h000;
            quanta_q <= '0;
        end else begin
            pend_q   <= pend_d;
            pvalid_q <= pvalid_d;
            quanta_q <= quanta_d;
        end
    end

    // APB register writes and read capture
    always_comb begin
        cfg_d    = cfg_q;
        rdata_d  = rdata_q;
        slverr_d = slverr_q;
        // Writes take effect in the access cycle
        if (apb_write) begin
            case (paddr)
                `OFS_CTRL: begin
                    cfg_d.forward_ctrl     = pwdata[`BIT_FWD];
                    cfg_d.check_ack        = pwdata[`BIT_CHK_ACK];
                    cfg_d.gcp_enable       = pwdata[`BIT_GCP_EN];
                    cfg_d.gcp_mcast_check  = pwdata[`BIT_GCP_MC];
                    cfg_d.gcp_ucast_check  = pwdata[`BIT_GCP_UC];
                    cfg_d.rx_global_ctrl_src_check = pwdata[`BIT_GCP_SA];
                    cfg_d.gcp_etype_check  = pwdata[`BIT_GCP_ET];
                    cfg_d.gcp_opcode_check = pwdata[`BIT_GCP_OP];
                    cfg_d.pcp_enable       = pwdata[`BIT_PCP_EN];
                    cfg_d.pcp_mcast_check  = pwdata[`BIT_PCP_MC];
                    cfg_d.pcp_ucast_check  = pwdata[`BIT_PCP_UC];
                    cfg_d.rx_prio_ctrl_src_check = pwdata[`BIT_PCP_SA];
                    cfg_d.pcp_etype_check  = pwdata[`BIT_PCP_ET];
                    cfg_d.pcp_opcode_check = pwdata[`BIT_PCP_OP];
                    cfg_d.gpp_enable       = pwdata[`BIT_GPP_EN];
                end
                `OFS_PAUSE_EN: cfg_d.pause_enable = pwdata[8:0];
                `OFS_UCAST_LO: begin
                    cfg_d.rx_pause_unicast_dest_addr[31:0] = pwdata;
                end
                `OFS_UCAST_HI: begin
                    cfg_d.rx_pause_unicast_dest_addr[47:32] =
                        pwdata[15:0];
                end
                `OFS_MCAST_LO: begin
                    cfg_d.rx_pause_multicast_dest_addr[31:0] =
                        pwdata;
                end
                `OFS_MCAST_HI: begin
                    cfg_d.rx_pause_multicast_dest_addr[47:32] =
                        pwdata[15:0];
                end
                `OFS_SRC_LO: begin
                    cfg_d.rx_pause_source_addr[31:0] = pwdata;
                end
                `OFS_SRC_HI: begin
                    cfg_d.rx_pause_source_addr[47:32] =
                        pwdata[15:0];
                end
                `OFS_ETYPE: begin
                    cfg_d.gcp_etype = pwdata[15:0];
                    cfg_d.pcp_etype = pwdata[31:16];
                end
                `OFS_GCP_OPC: begin
                    cfg_d.gcp_opcode_min = pwdata[15:0];
                    cfg_d.gcp_opcode_max = pwdata[31:16];
                end
                `OFS_PCP_OPC: begin
                    cfg_d.pcp_opcode_min = pwdata[15:0];
                    cfg_d.pcp_opcode_max = pwdata[31:16];
                end
                default: begin
                    // Status and unmapped words ignore writes
                end
            endcase
        end
        // Read data and error are captured in the setup cycle
        if (apb_setup) begin
            rdata_d  = 32'h0000_0000;
            slverr_d = 1'b0;
            case (paddr)
                `OFS_CTRL: begin
                    rdata_d[`BIT_FWD]     = cfg_q.forward_ctrl;
                    rdata_d[`BIT_CHK_ACK] = cfg_q.check_ack;
                    rdata_d[`BIT_GCP_EN]  = cfg_q.gcp_enable;
                    rdata_d[`BIT_GCP_MC]  = cfg_q.gcp_mcast_check;
                    rdata_d[`BIT_GCP_UC]  = cfg_q.gcp_ucast_check;
                    rdata_d[`BIT_GCP_SA]  = cfg_q.rx_global_ctrl_src_check;
                    rdata_d[`BIT_GCP_ET]  = cfg_q.gcp_etype_check;
                    rdata_d[`BIT_GCP_OP]  = cfg_q.gcp_opcode_check;
                    rdata_d[`BIT_PCP_EN]  = cfg_q.pcp_enable;
                    rdata_d[`BIT_PCP_MC]  = cfg_q.pcp_mcast_check;
                    rdata_d[`BIT_PCP_UC]  = cfg_q.pcp_ucast_check;
                    rdata_d[`BIT_PCP_SA]  = cfg_q.rx_prio_ctrl_src_check;
                    rdata_d[`BIT_PCP_ET]  = cfg_q.pcp_etype_check;
                    rdata_d[`BIT_PCP_OP]  = cfg_q.pcp_opcode_check;
                    rdata_d[`BIT_GPP_EN]  = cfg_q.gpp_enable;
                end
                `OFS_PAUSE_EN: rdata_d[8:0] = cfg_q.pause_enable;
                `OFS_UCAST_LO: begin
                    rdata_d = cfg_q.rx_pause_unicast_dest_addr[31:0];
                end
                `OFS_UCAST_HI: begin
                    rdata_d[15:0] = cfg_q.rx_pause_unicast_dest_addr[47:32];
                end
                `OFS_MCAST_LO: begin
                    rdata_d = cfg_q.rx_pause_multicast_dest_addr[31:0];
                end
                `OFS_MCAST_HI: begin
                    rdata_d[15:0] =
                        cfg_q.rx_pause_multicast_dest_addr[47:32];
                end
                `OFS_SRC_LO: rdata_d = cfg_q.rx_pause_source_addr[31:0];
                `OFS_SRC_HI: begin
                    rdata_d[15:0] = cfg_q.rx_pause_source_addr[47:32];
                end
                `OFS_ETYPE: begin
                    rdata_d = {cfg_q.pcp_etype, cfg_q.gcp_etype};
                end
                `OFS_GCP_OPC: begin
                    rdata_d = {cfg_q.gcp_opcode_max, cfg_q.gcp_opcode_min};
                end
                `OFS_PCP_OPC: begin
                    rdata_d = {cfg_q.pcp_opcode_max, cfg_q.pcp_opcode_min};
                end
                `OFS_STATUS: begin
                    // Live pause state for software
                    rdata_d[8:0] = pend_q;
                    rdata_d[`STAT_VALID_LSB +: 9] = pvalid_q;
                end
                default: begin
                    // Unmapped word reads zero with an error
                    slverr_d = 1'b1;
                end
            endcase
        end
    end

    // APB and configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q                <= '0;
            cfg_q.pause_enable   <= `RST_PAUSE_EN;
            cfg_q.gcp_etype      <= `RST_ETYPE;
            cfg_q.pcp_etype      <= `RST_ETYPE;
            cfg_q.gcp_opcode_min <= `RST_GCP_OPMIN;
            cfg_q.gcp_opcode_max <= `RST_GCP_OPMAX;
            cfg_q.pcp_opcode_min <= `RST_PCP_OPMIN;
            cfg_q.pcp_opcode_max <= `RST_PCP_OPMAX;
            rdata_q              <= 32'h0000_0000;
            slverr_q             <= 1'b0;
        end else begin
            cfg_q    <= cfg_d;
            rdata_q  <= rdata_d;
            slverr_q <= slverr_d;
        end
    end

    // Outputs
    assign prdata             = rdata_q;
    assign pready             = 1'b1;
    assign pslverr            = slverr_q & psel & penable;
    assign rx_verdict         = verdict_q;
    assign rx_verdict_valid   = vvalid_q;
    assign rx_pause_valid     = pvalid_q;
    assign rx_received_quanta = quanta_q;

endmodule

// >>> test/rx_pause_filter_monitor.sv
// Checker on the verdict and pause report ports of the qualifier.
`timescale 1ns/1ps
module rx_pause_filter_monitor (
    input wire logic                         pclk,    // Clock
    input wire logic                         presetn, // Reset, low
    input wire logic                         rx_hdr_valid,     // Header
    input wire rx_pause_filter_pkg::rx_hdr_t rx_hdr,           // Fields
    input wire logic [8:0]                   rx_pause_ack,     // User ack
    input wire rx_pause_filter_pkg::verdict_t rx_verdict,      // Verdict
    input wire logic                         rx_verdict_valid, // Pulse
    input wire logic [8:0]                   rx_pause_valid,   // Classes
    input wire logic [8:0][15:0]             rx_received_quanta // Quanta
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // A fresh global pause, not one that is still standing
    sequence new_global_s;
        rx_verdict_valid && rx_pause_valid[8] && !$past(rx_pause_valid[8]);
    endsequence
    AST_VERDICT_LAT: assert property (rx_hdr_valid |=> rx_verdict_valid)
        else $error("verdict missing one cycle after header");
    AST_NO_SPURIOUS: assert property (!rx_hdr_valid |=> !rx_verdict_valid)
        else $error("verdict without header");
    AST_ONE_ROUTE: assert property (rx_verdict_valid |->
        rx_verdict.deliver != rx_verdict.discard) else $error("bad route");
    AST_DROP_CTRL: assert property (rx_verdict_valid && rx_verdict.discard
        |-> rx_verdict.is_ctrl) else $error("data frame dropped");
    AST_IDLE_ZERO: assert property (!rx_verdict_valid |-> rx_verdict == '0)
        else $error("verdict not zero when idle");
    AST_GLOBAL_CAUSE: assert property ($rose(rx_pause_valid[8]) |->
        rx_verdict_valid && rx_verdict.is_ctrl) else $error("stray pause");
    AST_GLOBAL_QUANTA: assert property (new_global_s |->
        rx_received_quanta[8] == $past(rx_hdr.quanta[0]))
        else $error("global quanta wrong");
    AST_ACK_CLEAR: assert property (rx_pause_valid[8] && rx_pause_ack[8]
        && !rx_hdr_valid |=> !rx_pause_valid[8]) else $error("ack ignored");
endmodule

// >>> test/pause_user_model.sv
// User logic that acknowledges reported pause classes after a delay.
`timescale 1ns/1ps
module pause_user_model (
    input  wire logic       pclk,           // Clock
    input  wire logic       presetn,        // Reset, low
    input  wire logic [8:0] rx_pause_valid, // Reported classes
    input  wire logic [3:0] ack_delay,      // Cycles before ack
    output logic      [8:0] rx_pause_ack    // Ack per class
);
    logic [3:0] wait_q; // Cycles the pause has stood
    // Count the standing pause, then ack each standing class
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_q       <= '0;
            rx_pause_ack <= '0;
        end else begin
            wait_q       <= (|rx_pause_valid && !(|rx_pause_ack)) ? wait_q + 1 : '0;
            rx_pause_ack <= (wait_q >= ack_delay) ? rx_pause_valid : '0;
        end
    end
endmodule

// >>> test/rx_pause_filter_tb.sv
// Self-checking bench for the receive pause and control qualifier.
`timescale 1ns/1ps
`include "rx_pause_filter_defs.svh"
module rx_pause_filter_tb;
    logic pclk = 0, presetn = 0, psel, penable, pwrite, pready, pslverr, rerr;
    logic rx_hdr_valid, rx_verdict_valid;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat, got, exp_q[$];
    logic [47:0] uc, mc, sa, a;
    logic [3:0] ack_delay = 0;
    logic [8:0] rx_pause_ack, rx_pause_valid;
    logic [8:0][15:0] rx_received_quanta;
    rx_pause_filter_pkg::rx_hdr_t rx_hdr, h;
    rx_pause_filter_pkg::verdict_t rx_verdict;
    int errors = 0, compares = 0, n;
    rx_pause_filter i_rx_pause_filter (.*);
    pause_user_model i_pause_user_model (.*);
    initial forever #2.5 pclk = ~pclk;
    task automatic chk(string nm, logic [31:0] g, e);
        compares++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic stop_test;
        if (errors == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // APB transfer, held until pready is seen at an edge
    task automatic apb(logic w, logic [7:0] ad, logic [31:0] d);
        int k;
        k = 0;
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, ad, d};
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 40);
        if (k >= 40) begin
            errors++;
            stop_test;
        end
        {rdat, rerr} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
        @(posedge pclk);
    endtask
    function automatic rx_pause_filter_pkg::rx_hdr_t mk(
        logic [47:0] da, s, logic [15:0] op, et);
        mk = {da, s, et, op, 8'($urandom), {$urandom, $urandom,
              $urandom, $urandom}};
    endfunction
    // One header pulse; the expected result is noted first
    task automatic frame(rx_pause_filter_pkg::rx_hdr_t hd, logic [2:0] v,
                         logic [8:0] p);
        exp_q.push_back({4'h0, v, p, p[8] ? hd.quanta[0] : 16'h0});
        {rx_hdr, rx_hdr_valid} <= {hd, 1'b1};
        @(posedge pclk);
        rx_hdr_valid <= 0;
        @(posedge pclk);
    endtask
    // Each verdict pulse retires the oldest note
    always @(posedge pclk) begin
        if (rx_verdict_valid === 1'b1) begin
            got = {4'h0, rx_verdict, rx_pause_valid,
                   rx_pause_valid[8] ? rx_received_quanta[8] : 16'h0};
            chk("verdict", got, exp_q.size() ? exp_q.pop_front() : 'x);
        end
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata, rx_hdr_valid, rx_hdr} = '0;
        void'($urandom(32'h7013));
        uc = 48'({$urandom, $urandom});
        mc = 48'({$urandom, $urandom});
        sa = 48'({$urandom, $urandom});
        repeat (5) @(posedge pclk);
        presetn <= 1;
        apb(0, `OFS_PAUSE_EN, 0);
        chk("pause_en", rdat, 32'h1ff);
        apb(0, `OFS_ETYPE, 0);
        chk("etype", rdat, {2{`RST_ETYPE}});
        apb(0, 8'h3c, 0);
        chk("slverr", rerr, 1);
        frame(mk(uc, sa, 1, 16'h8808), 3'b100, 0);
        apb(1, `OFS_CTRL, 32'h40c4);
        frame(mk(uc, sa, 1, 16'h8808), 3'b011, 9'h100);
        frame(mk(uc, sa, 1, 16'h8809), 3'b100, 0);
        apb(1, `OFS_PAUSE_EN, 32'h0ff);
        frame(mk(uc, sa, 1, 16'h8808), 3'b011, 0);
        apb(1, `OFS_PAUSE_EN, 32'h1ff);
        apb(1, `OFS_GCP_OPC, 32'h0003_0001);
        for (int op = 0; op < 5; op++)
            frame(mk(uc, sa, 16'(op), 16'h8808), (op > 0 && op < 4) ? 3'b011
                  : 3'b100, {op == 1, 8'h0});
        for (int i = 0; i < 3; i++) begin
            a = i == 0 ? uc : (i == 1 ? mc : sa);
            apb(1, 8'(8 + 8 * i), a[31:0]);
            apb(1, 8'(12 + 8 * i), {16'h0, a[47:32]});
        end
        for (int p = 0; p < 2; p++)
            for (int k = 0; k < 5; k++) begin
                apb(1, `OFS_CTRL, 32'h4001 | (1 << (p*6+2)) | (1 << (p*6+3+k)));
                for (int bad = 0; bad < 2; bad++) begin
                    h = mk((k ? uc : mc) ^ bad, sa ^ bad,
                           (p ? 16'h0101 : 16'h1) ^ bad, 16'h8808 ^ bad);
                    frame(h, {2'b10, bad == 0}, bad ? 9'h0 : p ? {1'b0,
                          h.class_enable} : 9'h100);
                end
            end
        ack_delay <= 5;
        apb(1, `OFS_CTRL, 32'h4006);
        frame(mk(uc, sa, 1, 16'h8808), 3'b011, 9'h100);
        repeat (2) @(posedge pclk);
        chk("held", rx_pause_valid[8], 1);
        for (n = 0; n < 20 && rx_pause_valid[8] !== 1'b0; n++)
            @(posedge pclk);
        chk("acked", rx_pause_valid[8], 0);
        chk("left", exp_q.size(), 0);
        stop_test;
    end
endmodule
bind rx_pause_filter rx_pause_filter_monitor i_rx_pause_filter_monitor (.*);
